// File: dpr_defines.svh
// Constants for the dual-ported DMA RAM
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DPR_ADDR_W 16
`define DPR_DATA_W 16
`define DPR_SIZE_BYTES 2048
`define DPR_WORDS 1024
`define DPR_WIDX_W 10
`define DPR_BASE_ADDR 16'h3800
`define DPR_RESET_DATA 16'h0000

`endif

// File: dpr_pkg.sv
// Types for the dual-ported DMA RAM
`include "dpr_defines.svh"

package dpr_pkg;
    // ----------------------------------------
    // Port request and answer
    // ----------------------------------------
    typedef struct packed {
        logic en;
        logic we;
        logic byte_op;
        logic [`DPR_ADDR_W-1:0] addr;
        logic [`DPR_DATA_W-1:0] wdata;
    } dpr_req_type;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [`DPR_DATA_W-1:0] rdata;
    } dpr_rsp_type;
endpackage : dpr_pkg

// File: dpr_ram.sv
// Dual-ported RAM shared by processor core and DMA controller
//
// Overview of operation
// - 2 Kbyte RAM at top of data space, reached from two ports.
// - Core and DMA ports each complete an access in the same cycle.
// - DMA traffic never stalls or delays the core port.
// - Same-location writes in one cycle keep the core's value.
// - Core uses region as plain storage regardless of DMA activity.
// - Byte write changes only the lane picked by address bit 0.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defines.svh"

module dpr_ram (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Processor core port
    input wire dpr_pkg::dpr_req_type cpu_req,
    output var dpr_pkg::dpr_rsp_type cpu_rsp,
    // DMA controller port
    input wire dpr_pkg::dpr_req_type dma_req,
    output var dpr_pkg::dpr_rsp_type dma_rsp
);
    import dpr_pkg::*;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function automatic logic in_region(input logic [`DPR_ADDR_W-1:0] a);
        in_region = (a >= `DPR_BASE_ADDR) && (a < `DPR_BASE_ADDR + `DPR_SIZE_BYTES);
    endfunction : in_region

    function automatic logic [`DPR_WIDX_W-1:0] word_idx(input logic [`DPR_ADDR_W-1:0] a);
        word_idx = a[`DPR_WIDX_W:1];
    endfunction : word_idx

    function automatic logic [1:0] lanes(input dpr_req_type r);
        if (!r.byte_op) begin
            lanes = 2'h3;
        end else begin
            lanes = r.addr[0] ? 2'h2 : 2'h1;
        end
    endfunction : lanes

    logic [`DPR_DATA_W-1:0] cpu_old;
    logic [`DPR_DATA_W-1:0] dma_old;
    logic [`DPR_DATA_W-1:0] cpu_word;
    logic [`DPR_DATA_W-1:0] dma_word;
    logic [`DPR_WIDX_W-1:0] last_cpu_idx;
    logic [`DPR_WIDX_W-1:0] last_dma_idx;

    logic cpu_hit;
    logic dma_hit;
    logic [1:0] cpu_lane;
    logic [1:0] dma_lane;
    logic [`DPR_WIDX_W-1:0] cpu_idx;
    logic [`DPR_WIDX_W-1:0] dma_idx;
    logic [`DPR_DATA_W-1:0] cpu_wdata;
    logic [`DPR_DATA_W-1:0] dma_wdata;

    assign cpu_hit = cpu_req.en && in_region(cpu_req.addr);
    assign dma_hit = dma_req.en && in_region(dma_req.addr);
    assign cpu_lane = (cpu_hit && cpu_req.we) ? lanes(cpu_req) : 2'h0;
    assign dma_lane = (dma_hit && dma_req.we) ? lanes(dma_req) : 2'h0;
    assign cpu_idx = word_idx(cpu_req.addr);
    assign dma_idx = word_idx(dma_req.addr);
    // Byte data arrives in the low lane; copy it to both lanes
    assign cpu_wdata = cpu_req.byte_op ? {2{cpu_req.wdata[7:0]}} : cpu_req.wdata;
    assign dma_wdata = dma_req.byte_op ? {2{dma_req.wdata[7:0]}} : dma_req.wdata;

    // ----------------------------------------
    // Storage, one byte-wide array per lane
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic [7:0] lane_mem [0:`DPR_WORDS-1];

            always_ff @(posedge clk) begin
                if (clk_en) begin
                    // DMA first, core after, so the core wins a clash
                    if (dma_lane[g] && !(cpu_lane[g] && cpu_idx == dma_idx)) begin
                        lane_mem[dma_idx] <= dma_wdata[g*8 +: 8];
                    end
                    if (cpu_lane[g]) begin
                        lane_mem[cpu_idx] <= cpu_wdata[g*8 +: 8];
                    end
                end
            end

            // Contents before this edge's writes
            assign cpu_old[g*8 +: 8] = lane_mem[cpu_idx];
            assign dma_old[g*8 +: 8] = lane_mem[dma_idx];
            // Word last addressed, for the checks below
            assign cpu_word[g*8 +: 8] = lane_mem[last_cpu_idx];
            assign dma_word[g*8 +: 8] = lane_mem[last_dma_idx];
        end
    endgenerate

    // ----------------------------------------
    // Read answers, one cycle after the request
    // ----------------------------------------
    function automatic dpr_rsp_type answer(input dpr_req_type r, input logic hit,
                                           input logic [`DPR_DATA_W-1:0] w);
        answer.valid = r.en;
        answer.hit = hit;
        if (!hit || r.we) begin
            answer.rdata = `DPR_RESET_DATA;
        end else if (r.byte_op) begin
            answer.rdata = {8'h00, r.addr[0] ? w[15:8] : w[7:0]};
        end else begin
            answer.rdata = w;
        end
    endfunction : answer

    // Old contents are read, never the write of the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_rsp <= '0;
        end else if (clk_en) begin
            cpu_rsp <= answer(cpu_req, cpu_hit, cpu_old);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_rsp <= '0;
        end else if (clk_en) begin
            dma_rsp <= answer(dma_req, dma_hit, dma_old);
        end
    end

    // ----------------------------------------
    // Word index of the last enabled edge
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (clk_en) begin
            last_cpu_idx <= cpu_idx;
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en) begin
            last_dma_idx <= dma_idx;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence cpu_clash_s;
        clk_en && cpu_hit && cpu_req.we && !cpu_req.byte_op && dma_hit && dma_req.we && !dma_req.byte_op
            && dma_idx == cpu_idx;
    endsequence

    sequence cpu_alone_s;
        clk_en && cpu_hit && cpu_req.we && !cpu_req.byte_op && !dma_req.en;
    endsequence

    sequence dma_wr_high_s;
        clk_en && dma_hit && dma_req.we && dma_req.byte_op && dma_req.addr[0] && !cpu_req.en;
    endsequence

    sequence dma_rd_clash_s;
        clk_en && dma_hit && !dma_req.we && !dma_req.byte_op && cpu_hit && cpu_req.we && cpu_idx == dma_idx;
    endsequence

    // ----------------------------------------
    // Answer timing
    // ----------------------------------------
    chk_cpu_no_wait: assert property (clk_en && cpu_req.en |=> cpu_rsp.valid)
        else $error("core answer missing one cycle after request");
    chk_dma_no_wait: assert property (clk_en && dma_req.en |=> dma_rsp.valid)
        else $error("DMA answer missing one cycle after request");
    chk_both_answer: assert property (clk_en && cpu_req.en && dma_req.en |=> cpu_rsp.valid && dma_rsp.valid)
        else $error("simultaneous requests not both answered");
    chk_cpu_pulse: assert property (clk_en && !cpu_req.en |=> !cpu_rsp.valid)
        else $error("core answer without request");
    chk_dma_pulse: assert property (clk_en && !dma_req.en |=> !dma_rsp.valid)
        else $error("DMA answer without request");
    chk_cpu_freeze: assert property (!clk_en |=> $stable(cpu_rsp))
        else $error("core answer moved while clock enable low");
    chk_dma_freeze: assert property (!clk_en |=> $stable(dma_rsp))
        else $error("DMA answer moved while clock enable low");

    // ----------------------------------------
    // Storage contents
    // ----------------------------------------
    chk_cpu_wins: assert property (cpu_clash_s |=> cpu_word == $past(cpu_req.wdata))
        else $error("core write not kept after same-cycle clash");
    chk_cpu_storage: assert property (cpu_alone_s |=> cpu_word == $past(cpu_req.wdata))
        else $error("core write not stored");

    // ----------------------------------------
    // Region decode, lanes and old-value reads
    // ----------------------------------------
    chk_region_hit: assert property (clk_en && cpu_req.en |=>
                                     cpu_rsp.hit == ($past(cpu_req.addr) >= `DPR_BASE_ADDR &&
                                                     $past(cpu_req.addr) <= `DPR_BASE_ADDR + `DPR_SIZE_BYTES - 1))
        else $error("region decode wrong");
    chk_dma_region_hit: assert property (clk_en && dma_req.en |=>
                                         dma_rsp.hit == ($past(dma_req.addr) >= `DPR_BASE_ADDR &&
                                                         $past(dma_req.addr) <= `DPR_BASE_ADDR + `DPR_SIZE_BYTES - 1))
        else $error("DMA region decode wrong");
    chk_miss_zero: assert property (clk_en && dma_req.en && !dma_hit |=> dma_rsp.rdata == 16'h0000)
        else $error("out-of-region read not zero");
    chk_byte_high: assert property (clk_en && cpu_hit && !cpu_req.we && cpu_req.byte_op |=>
                                    cpu_rsp.rdata[15:8] == 8'h00)
        else $error("byte read upper lane not zero");
    chk_dma_lane_keep: assert property (dma_wr_high_s |=>
                                        dma_word == {$past(dma_req.wdata[7:0]), $past(dma_old[7:0])})
        else $error("byte write disturbed the other lane");
    chk_old_read: assert property (dma_rd_clash_s |=> dma_rsp.rdata == $past(dma_old))
        else $error("colliding read did not return old value");
endmodule : dpr_ram

`default_nettype wire

// File: dpr_master.sv
// Request model for one port of the dual-ported RAM
`timescale 1ns/1ps
`default_nettype none

module dpr_master (
    // Clock
    input wire logic clk,
    // Port
    output var dpr_pkg::dpr_req_type req,
    input wire dpr_pkg::dpr_rsp_type rsp
);
    import dpr_pkg::*;

    initial req = '0;

    // One access; released lines show the inverse of the last values
    task automatic xfer(input logic we, input logic bo, input logic [15:0] a, input logic [15:0] d,
                        output logic [17:0] r);
        @(posedge clk);
        #1;
        req = '{1'b1, we, bo, a, d};
        @(posedge clk);
        #1;
        r = rsp;
        req = '{1'b0, ~we, ~bo, ~a, ~d};
    endtask : xfer
endmodule : dpr_master

`default_nettype wire

// File: dpr_ram_test.sv
// Self-checking testbench for the dual-ported RAM
`timescale 1ns/1ps
`default_nettype none

module dpr_ram_test;
    import dpr_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    dpr_req_type cpu_req;
    dpr_req_type dma_req;
    dpr_rsp_type cpu_rsp;
    dpr_rsp_type dma_rsp;
    int miscompares = 0;
    int cmp_count = 0;
    logic [17:0] rc;
    logic [17:0] rd;

    dpr_ram u_dpr_ram (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
                       .dma_req(dma_req), .dma_rsp(dma_rsp));
    dpr_master u_cpu (.clk(clk), .req(cpu_req), .rsp(cpu_rsp));
    dpr_master u_dma (.clk(clk), .req(dma_req), .rsp(dma_rsp));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic t_plain;
        u_cpu.xfer(1'b1, 1'b0, 16'h3800, 16'h1234, rc);
        chk("cpu write", 18'h30000, rc);
        u_cpu.xfer(1'b0, 1'b0, 16'h3800, 16'h0000, rc);
        chk("cpu read", 18'h31234, rc);
        u_cpu.xfer(1'b0, 1'b0, 16'h37FE, 16'h0000, rc);
        chk("below region", 18'h20000, rc);
        u_dma.xfer(1'b1, 1'b0, 16'h3FFE, 16'h7E57, rd);
        u_cpu.xfer(1'b0, 1'b0, 16'h3FFE, 16'h0000, rc);
        chk("top word", 18'h37E57, rc);
        u_dma.xfer(1'b0, 1'b0, 16'h4000, 16'h0000, rd);
        chk("above region", 18'h20000, rd);
    endtask : t_plain

    task automatic t_both;
        fork
            u_cpu.xfer(1'b1, 1'b0, 16'h3802, 16'hAAAA, rc);
            u_dma.xfer(1'b1, 1'b0, 16'h3804, 16'h5555, rd);
        join
        chk("cpu same cycle", 18'h30000, rc);
        chk("dma same cycle", 18'h30000, rd);
        fork
            u_cpu.xfer(1'b0, 1'b0, 16'h3804, 16'h0000, rc);
            u_dma.xfer(1'b0, 1'b0, 16'h3802, 16'h0000, rd);
        join
        chk("cpu cross read", 18'h35555, rc);
        chk("dma cross read", 18'h3AAAA, rd);
    endtask : t_both

    task automatic t_clash;
        fork
            u_cpu.xfer(1'b1, 1'b0, 16'h3806, 16'hC0DE, rc);
            u_dma.xfer(1'b1, 1'b0, 16'h3806, 16'hBEEF, rd);
        join
        u_dma.xfer(1'b0, 1'b0, 16'h3806, 16'h0000, rd);
        chk("clash winner", 18'h3C0DE, rd);
    endtask : t_clash

    task automatic t_byte;
        u_cpu.xfer(1'b1, 1'b0, 16'h3808, 16'h1234, rc);
        u_dma.xfer(1'b1, 1'b1, 16'h3809, 16'h00AB, rd);
        u_cpu.xfer(1'b0, 1'b0, 16'h3808, 16'h0000, rc);
        chk("byte lane word", 18'h3AB34, rc);
        u_cpu.xfer(1'b0, 1'b1, 16'h3809, 16'h0000, rc);
        chk("byte read", 18'h300AB, rc);
    endtask : t_byte

    task automatic t_old;
        u_cpu.xfer(1'b1, 1'b0, 16'h380A, 16'h1111, rc);
        fork
            u_cpu.xfer(1'b0, 1'b0, 16'h380A, 16'h0000, rc);
            u_dma.xfer(1'b1, 1'b0, 16'h380A, 16'h2222, rd);
        join
        chk("read old", 18'h31111, rc);
        u_cpu.xfer(1'b0, 1'b0, 16'h380A, 16'h0000, rc);
        chk("read new", 18'h32222, rc);
        fork
            u_cpu.xfer(1'b1, 1'b0, 16'h380A, 16'h3333, rc);
            u_dma.xfer(1'b0, 1'b0, 16'h380A, 16'h0000, rd);
        join
        chk("dma read old", 18'h32222, rd);
    endtask : t_old

    task automatic t_freeze;
        u_cpu.xfer(1'b1, 1'b0, 16'h380C, 16'h4321, rc);
        clk_en = 1'b0;
        u_cpu.xfer(1'b1, 1'b0, 16'h380C, 16'h9999, rc);
        chk("frozen answer", 18'h30000, rc);
        clk_en = 1'b1;
        u_cpu.xfer(1'b0, 1'b0, 16'h380C, 16'h0000, rc);
        chk("frozen write", 18'h34321, rc);
    endtask : t_freeze

    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_plain();
        t_both();
        t_clash();
        t_byte();
        t_old();
        t_freeze();
        give_verdict();
    end
endmodule : dpr_ram_test

`default_nettype wire
